// file: hdl/tcpwm_consts.vh
`ifndef TCPWM_CONSTS_VH
`define TCPWM_CONSTS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define TCPWM_NUM_CH        4
`define TCPWM_CNT_W         16
`define TCPWM_ADDR_W        12

// ----------------------------------------
// Register byte offsets (per-channel block of 32 bytes; prescale is one global register at 0x080)
// ----------------------------------------
`define TCPWM_OFF_CTRL      5'h00
`define TCPWM_OFF_PERIOD    5'h04
`define TCPWM_OFF_COMPARE   5'h08
`define TCPWM_OFF_COUNT     5'h0C
`define TCPWM_OFF_CAPTURE   5'h10
`define TCPWM_OFF_STATUS    5'h14
`define TCPWM_OFF_MASK      5'h18
`define TCPWM_OFF_PRESCALE  12'h080

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TCPWM_CTRL_RUN      0
`define TCPWM_CTRL_MODE_LO  1
`define TCPWM_CTRL_MODE_HI  2
`define TCPWM_CTRL_CSEL_LO  3
`define TCPWM_CTRL_CSEL_HI  4
`define TCPWM_CTRL_REL_LO   5
`define TCPWM_CTRL_REL_HI   7
`define TCPWM_CTRL_CPL      8
`define TCPWM_CTRL_DB_LO    16
`define TCPWM_CTRL_DB_HI    23
`define TCPWM_CTRL_ACTIVE   31
`define TCPWM_CTRL_WMASK    32'h00FF01FF

// ----------------------------------------
// Encodings
// ----------------------------------------
`define TCPWM_MODE_FREE     2'h0
`define TCPWM_MODE_ONESHOT  2'h1
`define TCPWM_MODE_GATED    2'h2
`define TCPWM_REL_LESS_THAN       3'h0
`define TCPWM_REL_LESS_OR_SAME    3'h1
`define TCPWM_REL_MATCH_SAME      3'h2
`define TCPWM_REL_GREATER_OR_SAME 3'h3
`define TCPWM_REL_GREATER_STRICT  3'h4
`define TCPWM_ST_TC         0
`define TCPWM_ST_CMP        1
`define TCPWM_ST_CAP        2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TCPWM_CTRL_RST      32'h00000000
`define TCPWM_PERIOD_RST    16'hFFFF
`define TCPWM_COMPARE_RST   16'h8000
`define TCPWM_PRESCALE_RST  16'h0000
`define TCPWM_EVT_RST       3'h0

`endif

// file: hdl/tcpwm_top.v
`timescale 1ns/1ps
// Behaviour
// - Sixteen-bit counter, counts down only
// - Four instances, compare, terminal-count, interrupt each
// - Terminal-count pin may carry inverted compare
// - Counter clock selected from several sources
// - Modes: free run, one-shot, gated
// - Gated mode decrements only while enable high
// - One-shot stops after one period, no reload
// - Period loads on start, reset, terminal count
// - Capture snapshots count; count readable anytime
// - Compare relation: lt, le, eq, ge, gt
// - Interrupt on terminal count, compare, capture
// - Complementary PWM pair with deadband
// - Kill forces PWM outputs off
// - Reset input restarts count, capture input snapshots
`include "tcpwm_consts.vh"

module tcpwm_chan (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        tick,
  input  wire        run,
  input  wire [1:0]  mode,
  input  wire [2:0]  rel,
  input  wire        cpl,
  input  wire [7:0]  deadband,
  input  wire [15:0] period,
  input  wire [15:0] compare,
  input  wire        en_in,
  input  wire        rst_in,
  input  wire        cap_in,
  input  wire        kill_in,
  output reg  [15:0] count,
  output reg  [15:0] capture,
  output reg         cmp_out,
  output reg         tc_out,
  output wire        tc_evt,
  output wire        cmp_evt,
  output wire        cap_evt,
  output wire        active
);
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RUN  = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg  [2:0] state;
  reg        run_q;
  reg        rst_q;
  reg        cap_q;
  reg        tc_q;
  reg        cmp_q;
  reg        cmp_raw;
  reg  [7:0] db_cnt;
  wire       start    = run & ~run_q;
  wire       rst_edge = rst_in & ~rst_q;
  wire       db_idle  = (db_cnt == 8'h00);
  wire       gate_ok  = (mode != `TCPWM_MODE_GATED) | en_in;
  wire       step     = tick & state[1] & gate_ok;
  wire       pwm_p    = cmp_q & db_idle & ~kill_in;
  wire       pwm_n    = ~cmp_q & db_idle & ~kill_in & ~state[0];

  assign active  = state[1];
  assign cap_evt = cap_in & ~cap_q;
  assign tc_evt  = step & run & ~rst_edge & ~tc_q & (count == 16'h0001);
  assign cmp_evt = cmp_raw & ~cmp_q & state[1];

  // ----------------------------------------
  // Compare relation
  // ----------------------------------------
  always @* begin
    case (rel)
      `TCPWM_REL_LESS_THAN:       cmp_raw = (count <  compare);
      `TCPWM_REL_LESS_OR_SAME:    cmp_raw = (count <= compare);
      `TCPWM_REL_MATCH_SAME:      cmp_raw = (count == compare);
      `TCPWM_REL_GREATER_OR_SAME: cmp_raw = (count >= compare);
      `TCPWM_REL_GREATER_STRICT:  cmp_raw = (count >  compare);
      default:                    cmp_raw = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Counter state machine
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      count <= `TCPWM_PERIOD_RST;
      tc_q  <= 1'b0;
      run_q <= 1'b0;
      rst_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      run_q <= run;
      rst_q <= rst_in;
      cap_q <= cap_in;
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_RUN;
            count <= period;
            tc_q  <= (period == 16'h0000);
          end else if (rst_edge) begin
            count <= period;
          end
        end
        ST_RUN: begin
          if (!run) begin
            state <= ST_IDLE;
            tc_q  <= 1'b0;
          end else if (rst_edge) begin
            count <= period;
            tc_q  <= (period == 16'h0000);
          end else if (step) begin
            if (tc_q) begin
              tc_q <= 1'b0;
              if (mode == `TCPWM_MODE_ONESHOT)
                state <= ST_DONE;
              else
                count <= period;
            end else begin
              count <= count - 16'h0001;
              tc_q  <= (count == 16'h0001);
            end
          end
        end
        ST_DONE: begin
          if (!run) begin
            state <= ST_IDLE;
          end else if (rst_edge) begin
            state <= ST_RUN;
            count <= period;
            tc_q  <= (period == 16'h0000);
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Capture, deadband and outputs
  // ----------------------------------------
  // Outputs are registered, so kill takes hold one pclk after it rises
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture <= 16'h0000;
      cmp_q   <= 1'b0;
      db_cnt  <= 8'h00;
      cmp_out <= 1'b0;
      tc_out  <= 1'b0;
    end else begin
      if (cap_evt)
        capture <= count;
      cmp_q <= cmp_raw;
      if (cmp_raw != cmp_q)
        db_cnt <= deadband;
      else if (tick && !db_idle)
        db_cnt <= db_cnt - 8'h01;
      cmp_out <= pwm_p;
      tc_out  <= cpl ? pwm_n : tc_q;
    end
  end
endmodule // tcpwm_chan

module tcpwm_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire [1:0]  ext_tick,
  input  wire [3:0]  ctr_enable,
  input  wire [3:0]  ctr_reset,
  input  wire [3:0]  ctr_capture,
  input  wire [3:0]  ctr_kill,
  output wire [3:0]  cmp_out,
  output wire [3:0]  tc_out,
  output wire [3:0]  irq_line,
  output wire        irq
);
  reg  [31:0] ctrl     [0:3];
  reg  [15:0] period   [0:3];
  reg  [15:0] compare  [0:3];
  reg  [2:0]  status   [0:3];
  reg  [2:0]  mask     [0:3];
  reg  [15:0] prescale;
  reg  [15:0] pre_cnt;
  wire [15:0] count    [0:3];
  wire [15:0] capture  [0:3];
  wire [3:0]  active;
  wire [2:0]  evt      [0:3];
  wire        pre_tick = (pre_cnt == 16'h0000);
  wire        wr_acc   = psel & penable & pwrite;
  wire        ch_sel   = (paddr[11:7] == 5'h00);
  wire [1:0]  ch       = paddr[6:5];
  wire [4:0]  off      = paddr[4:0];
  reg  [31:0] rd_mux;
  reg         rd_err;
  integer     i;

  assign pready = 1'b1;
  assign irq    = |irq_line;

  // ----------------------------------------
  // Prescaler: one-pclk enable every prescale+1 clocks
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_cnt <= `TCPWM_PRESCALE_RST;
    else if (pre_tick)
      pre_cnt <= prescale;
    else
      pre_cnt <= pre_cnt - 16'h0001;
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `TCPWM_NUM_CH; g = g + 1) begin : gen_ch
      reg tick;
      always @* begin
        case (ctrl[g][`TCPWM_CTRL_CSEL_HI:`TCPWM_CTRL_CSEL_LO])
          2'h0:    tick = 1'b1;
          2'h1:    tick = pre_tick;
          2'h2:    tick = ext_tick[0];
          default: tick = ext_tick[1];
        endcase
      end
      tcpwm_chan u_chan (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick),
        .run      (ctrl[g][`TCPWM_CTRL_RUN]),
        .mode     (ctrl[g][`TCPWM_CTRL_MODE_HI:`TCPWM_CTRL_MODE_LO]),
        .rel      (ctrl[g][`TCPWM_CTRL_REL_HI:`TCPWM_CTRL_REL_LO]),
        .cpl      (ctrl[g][`TCPWM_CTRL_CPL]),
        .deadband (ctrl[g][`TCPWM_CTRL_DB_HI:`TCPWM_CTRL_DB_LO]),
        .period   (period[g]),
        .compare  (compare[g]),
        .en_in    (ctr_enable[g]),
        .rst_in   (ctr_reset[g]),
        .cap_in   (ctr_capture[g]),
        .kill_in  (ctr_kill[g]),
        .count    (count[g]),
        .capture  (capture[g]),
        .cmp_out  (cmp_out[g]),
        .tc_out   (tc_out[g]),
        .tc_evt   (evt[g][`TCPWM_ST_TC]),
        .cmp_evt  (evt[g][`TCPWM_ST_CMP]),
        .cap_evt  (evt[g][`TCPWM_ST_CAP]),
        .active   (active[g])
      );
      assign irq_line[g] = |(status[g] & mask[g]);
    end
  endgenerate

  // ----------------------------------------
  // Register writes; hardware set wins over write-one-clear
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `TCPWM_NUM_CH; i = i + 1) begin
        ctrl[i]    <= `TCPWM_CTRL_RST;
        period[i]  <= `TCPWM_PERIOD_RST;
        compare[i] <= `TCPWM_COMPARE_RST;
        status[i]  <= `TCPWM_EVT_RST;
        mask[i]    <= `TCPWM_EVT_RST;
      end
      prescale <= `TCPWM_PRESCALE_RST;
    end else begin
      for (i = 0; i < `TCPWM_NUM_CH; i = i + 1) begin
        if (wr_acc && ch_sel && ch == i[1:0] && off == `TCPWM_OFF_STATUS)
          status[i] <= (status[i] & ~pwdata[2:0]) | evt[i];
        else
          status[i] <= status[i] | evt[i];
      end
      if (wr_acc && ch_sel) begin
        case (off)
          `TCPWM_OFF_CTRL:    ctrl[ch]    <= pwdata & `TCPWM_CTRL_WMASK;
          `TCPWM_OFF_PERIOD:  period[ch]  <= pwdata[15:0];
          `TCPWM_OFF_COMPARE: compare[ch] <= pwdata[15:0];
          `TCPWM_OFF_MASK:    mask[ch]    <= pwdata[2:0];
          default:            ;
        endcase
      end
      if (wr_acc && paddr == `TCPWM_OFF_PRESCALE)
        prescale <= pwdata[15:0];
    end
  end

  // ----------------------------------------
  // Read mux, sampled in the setup phase
  // ----------------------------------------
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    if (ch_sel) begin
      case (off)
        `TCPWM_OFF_CTRL: begin
          rd_mux = ctrl[ch];
          rd_mux[`TCPWM_CTRL_ACTIVE] = active[ch];
        end
        `TCPWM_OFF_PERIOD:  rd_mux = {16'h0000, period[ch]};
        `TCPWM_OFF_COMPARE: rd_mux = {16'h0000, compare[ch]};
        `TCPWM_OFF_COUNT:   rd_mux = {16'h0000, count[ch]};
        `TCPWM_OFF_CAPTURE: rd_mux = {16'h0000, capture[ch]};
        `TCPWM_OFF_STATUS:  rd_mux = {29'h00000000, status[ch]};
        `TCPWM_OFF_MASK:    rd_mux = {29'h00000000, mask[ch]};
        default:            rd_err = 1'b1;
      endcase
    end else if (paddr == `TCPWM_OFF_PRESCALE) begin
      rd_mux = {16'h0000, prescale};
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= rd_err;
    end
  end
endmodule // tcpwm_top

// file: sim/tcpwm_checker.sv
`timescale 1ns/1ps
module tcpwm_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        pready,
  input wire [3:0]  ctr_kill,
  input wire [3:0]  cmp_out,
  input wire [3:0]  tc_out,
  input wire [3:0]  irq_line,
  input wire        irq
);
  // ----
  // Bus phases
  // ----
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire mapped = (paddr == 12'h080) ||
                (paddr < 12'h080 && paddr[1:0] == 2'h0 && paddr[4:0] <= 5'h18);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  a_zero_wait: assert property (setup_s ##1 access_s |-> pready)
    else $error("pready low in access");
  a_unmapped_err: assert property (setup_s ##1 access_s |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_err_reads_zero: assert property (
    setup_s ##1 (access_s and (!pwrite && pslverr)) |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_rdata_holds: assert property ((!psel || penable) |=> $stable(prdata))
    else $error("prdata moved outside setup");
  a_err_holds: assert property ((!psel || penable) |=> $stable(pslverr))
    else $error("pslverr moved outside setup");
  a_irq_is_or: assert property (irq == |irq_line)
    else $error("irq differs from lines");
  a_kill_forces_off: assert property (
    ctr_kill != 4'h0 |=> (cmp_out & $past(ctr_kill)) == 4'h0)
    else $error("compare high under kill");
  a_reset_quiet: assert property (
    $rose(presetn) |-> !irq && (cmp_out | tc_out | irq_line) == 4'h0)
    else $error("outputs active after reset");
endmodule // tcpwm_checker

bind tcpwm_top tcpwm_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .pready(pready),
  .ctr_kill(ctr_kill), .cmp_out(cmp_out), .tc_out(tc_out), .irq_line(irq_line), .irq(irq));

// file: sim/test_tcpwm_top.sv
`timescale 1ns/1ps
`include "tcpwm_consts.vh"
module test_tcpwm_top;
  reg         pclk, presetn, psel, penable, pwrite, er;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [1:0]  ext_tick;
  reg  [3:0]  ctr_enable, ctr_reset, ctr_capture, ctr_kill;
  wire [31:0] prdata;
  wire        pready, pslverr, irq;
  wire [3:0]  cmp_out, tc_out, irq_line;
  integer     error_cnt, n_compared, r;

  tcpwm_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_tick(ext_tick), .ctr_enable(ctr_enable), .ctr_reset(ctr_reset),
    .ctr_capture(ctr_capture), .ctr_kill(ctr_kill), .cmp_out(cmp_out), .tc_out(tc_out),
    .irq_line(irq_line), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----
  // Tasks
  // ----
  task final_report;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input [127:0] nm, input [31:0] ex, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== ex) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s expected %h seen %h", nm, ex, got);
      end
    end
  endtask

  // Idle edge after release, so psel is never driven twice in a step
  task apb(input wr, input [11:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16) begin
        n = n + 1;
        @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 16) begin
        error_cnt = error_cnt + 1;
        final_report;
      end
      @(posedge pclk);
    end
  endtask

  task rdk(input [127:0] nm, input [11:0] a, input [31:0] ex);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, ex, rd);
    end
  endtask

  task tk(input integer b, input integer n);
    repeat (n) begin
      ext_tick[b] <= 1'b1;
      @(posedge pclk);
      ext_tick[b] <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // ----
  // Sequence
  // ----
  initial begin
    error_cnt = 0;
    n_compared = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext_tick = 2'h0;
    {ctr_enable, ctr_reset, ctr_capture, ctr_kill} = 16'h0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdk("ctrl", 12'h000, `TCPWM_CTRL_RST);
    rdk("period", 12'h004, {16'h0000, `TCPWM_PERIOD_RST});
    rdk("compare", 12'h008, {16'h0000, `TCPWM_COMPARE_RST});
    rdk("count", 12'h00C, 32'h0000FFFF);
    apb(1'b0, 12'h084, 32'h0);
    chk("rd_err", 32'h1, er);
    chk("rd_zero", 32'h0, rd);
    // One-shot on external tick source
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h018, 32'h1);
    apb(1'b1, 12'h000, 32'h13);
    rdk("load", 12'h00C, 32'h3);
    tk(0, 2);
    rdk("dec", 12'h00C, 32'h1);
    tk(0, 3);
    rdk("stop", 12'h00C, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk("st_tc", 32'h1, rd[0]);
    chk("irq", 32'h1, irq);
    apb(1'b1, 12'h018, 32'h0);
    chk("masked", 32'h0, irq_line[0]);
    apb(1'b1, 12'h014, 32'h7);
    apb(1'b1, 12'h018, 32'h1);
    chk("cleared", 32'h0, irq);
    // Gated count, capture, reload
    apb(1'b1, 12'h024, 32'hA);
    apb(1'b1, 12'h020, 32'h5);
    rdk("gate_hold", 12'h02C, 32'hA);
    ctr_enable[1] <= 1'b1;
    repeat (4) @(posedge pclk);
    ctr_enable[1] <= 1'b0;
    @(posedge pclk);
    rdk("gate_run", 12'h02C, 32'h6);
    ctr_capture[1] <= 1'b1;
    @(posedge pclk);
    ctr_capture[1] <= 1'b0;
    @(posedge pclk);
    rdk("capture", 12'h030, 32'h6);
    apb(1'b0, 12'h034, 32'h0);
    chk("st_cap", 32'h1, rd[2]);
    ctr_reset[1] <= 1'b1;
    @(posedge pclk);
    ctr_reset[1] <= 1'b0;
    @(posedge pclk);
    rdk("reload", 12'h02C, 32'hA);
    // Every relation, complementary pin, kill
    apb(1'b1, 12'h044, 32'h5);
    apb(1'b1, 12'h048, 32'h5);
    for (r = 0; r < 5; r = r + 1) begin
      apb(1'b1, 12'h040, 32'h105 | (r << 5));
      repeat (4) @(posedge pclk);
      chk("cmp", (r >= 1 && r <= 3), cmp_out[2]);
      chk("cpl", (r == 0 || r == 4), tc_out[2]);
      ctr_kill[2] <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("kill", 32'h0, {cmp_out[2], tc_out[2]});
      ctr_kill[2] <= 1'b0;
    end
    // Prescaled source, gated: four enabled pclks hold exactly two ticks
    apb(1'b1, 12'h080, 32'h1);
    rdk("prescale", 12'h080, 32'h1);
    apb(1'b1, 12'h020, 32'hD);
    ctr_enable[1] <= 1'b1;
    repeat (4) @(posedge pclk);
    ctr_enable[1] <= 1'b0;
    @(posedge pclk);
    rdk("pre_tick", 12'h02C, 32'h8);
    // Free run on ext_tick[1]: terminal-count pin and reload
    apb(1'b1, 12'h064, 32'h2);
    apb(1'b1, 12'h068, 32'h1);
    apb(1'b1, 12'h060, 32'h99);
    tk(1, 2);
    rdk("tc_zero", 12'h06C, 32'h0);
    chk("tc_pin", 32'h1, tc_out[3]);
    tk(1, 1);
    rdk("free_reload", 12'h06C, 32'h2);
    chk("tc_low", 32'h0, tc_out[3]);
    apb(1'b0, 12'h074, 32'h0);
    chk("st_tc3", 32'h1, rd[0]);
    // Deadband: gated, so the count holds while ticks run the band down
    apb(1'b1, 12'h060, 32'h0002019D);
    apb(1'b1, 12'h068, 32'h3);
    tk(1, 1);
    chk("db_p", 32'h0, cmp_out[3]);
    chk("db_n", 32'h0, tc_out[3]);
    tk(1, 2);
    chk("db_done", 32'h1, tc_out[3]);
    chk("db_p_off", 32'h0, cmp_out[3]);
    final_report;
  end
endmodule // test_tcpwm_top
